// ---- rtl/dtf_pkg.sv ----
package dtf_pkg;

  // register offsets
  localparam logic [7:0] ADDR_INTCTL = 8'h0B;
  localparam logic [7:0] ADDR_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_T1_LO = 8'h0E;
  localparam logic [7:0] ADDR_T1_HI = 8'h0F;
  localparam logic [7:0] ADDR_T1_CTRL = 8'h10;
  localparam logic [7:0] ADDR_T2_COUNT = 8'h11;
  localparam logic [7:0] ADDR_T2_CTRL = 8'h12;
  localparam logic [7:0] ADDR_ENABLES = 8'h8C;
  localparam logic [7:0] ADDR_T2_PERIOD = 8'h92;

  // first_timer_control fields
  localparam int T1_ON_BIT = 0;
  localparam int T1_SRC_BIT = 1;
  localparam int T1_SYNC_BIT = 2;
  localparam int T1_OSC_BIT = 3;
  localparam int T1_PS_LSB = 4;

  // second_timer_control fields
  localparam int T2_PS_LSB = 0;
  localparam int T2_RUN_BIT = 2;
  localparam int T2_POST_LSB = 3;

  // flag, enable and interrupt_control fields
  localparam int FLAG_T1_BIT = 0;
  localparam int FLAG_T2_BIT = 1;
  localparam int INTCTL_GIE_BIT = 1;
  localparam int INTCTL_PEIE_BIT = 0;
  localparam int INTCTL_LSB = 6;

  // pin indices into the synchronised pair
  localparam int PIN_CKI = 0;
  localparam int PIN_OSC = 1;

  // phase clock positions within one instruction cycle
  localparam logic [1:0] PHASE_Q2 = 2'h1;
  localparam logic [1:0] PHASE_Q4 = 2'h3;

  // second timer prescale terminal counts (ratio minus one)
  localparam logic [3:0] T2_DIV_00 = 4'h0;
  localparam logic [3:0] T2_DIV_01 = 4'h3;
  localparam logic [3:0] T2_DIV_1X = 4'hF;

  // reset values
  localparam logic [7:0] T2_PERIOD_RST = 8'hFF;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } dtf_bus_req_type;

  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] stable;
  } dtf_sync_type;

  typedef struct packed {
    logic [1:0] phase;
    logic [5:0] t1_ctrl;
    logic [15:0] t1_count;
    logic [2:0] t1_pre;
    logic pin_prev;
    logic pre_prev;
    logic sampled;
    logic sampled_prev;
    logic [7:0] t2_count;
    logic [6:0] t2_ctrl;
    logic [7:0] t2_period;
    logic [3:0] t2_pre;
    logic [3:0] t2_post;
    logic [1:0] flags;
    logic [1:0] enables;
    logic [1:0] intctl;
    logic [7:0] rdata;
    logic irq;
  } dtf_state_type;

  localparam dtf_state_type STATE_RST = '{
    t2_period: T2_PERIOD_RST,
    default: '0
  };

endpackage

// ---- rtl/dtf_pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module dtf_pin_sync (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // asynchronous pins and their synchronised copies
  input wire logic [1:0] pins_i,
  output logic [1:0] pins_o
);
  import dtf_pkg::*;

  dtf_sync_type sync_reg, sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.meta = pins_i;
    sync_next.stable = sync_reg.meta;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      sync_reg <= '0;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign pins_o = sync_reg.stable;

endmodule // dtf_pin_sync

`default_nettype wire

// ---- rtl/dtf_timers.sv ----
`timescale 1ns/10ps
`default_nettype none

// Function
// - source select clear: first timer counts one per instruction cycle.
// - in timer mode the sync control bit changes nothing.
// - source select set: count rising edges of the chosen external pin.
// - external clock runs through prescaler, then optional phase sync.
// - synced counter mode holds count in sleep; prescaler keeps counting.
// - synced counter mode increments a sync delay after the edge.
// - at 1:1 the prescaler output is sampled on second and fourth phase.
// - control bit 2 turns the second timer on or off.
// - overflow of first timer sets a sticky flag until software clears.
// - flags set regardless of enables or the global enable.
// - every reset clears the second timer count.
module dtf_timers (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic srst_i,
  // register port
  input wire dtf_pkg::dtf_bus_req_type bus_req_i,
  output logic [7:0] rdata_o,
  // external clock pins and core sleep state
  input wire logic osc_in_i,
  input wire logic clk_pin_i,
  input wire logic sleep_i,
  // interrupt
  output logic irq_o
);
  import dtf_pkg::*;

  dtf_state_type state_reg, state_next;
  logic [1:0] pins_sync;
  logic t1_inc;
  logic t2_tick;

  dtf_pin_sync u_pin_sync (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .pins_i({osc_in_i, clk_pin_i}),
    .pins_o(pins_sync)
  );

  always_comb begin
    logic instr_tick;
    logic ext_level;
    logic pre_out;
    logic [1:0] t1_ps;
    logic [3:0] t2_limit;
    logic [1:0] flag_set;
    logic [7:0] rd_mux;
    instr_tick = 1'b0;
    ext_level = 1'b0;
    pre_out = 1'b0;
    t1_ps = 2'h0;
    t2_limit = T2_DIV_00;
    flag_set = 2'b00;
    rd_mux = 8'h00;
    t1_inc = 1'b0;
    t2_tick = 1'b0;
    state_next = state_reg;

    // quarter-rate phase counter; the last phase closes an instruction cycle
    state_next.phase = state_reg.phase + 2'h1;
    instr_tick = (state_reg.phase == PHASE_Q4);

    // external source choice and ripple prescaler
    ext_level = state_reg.t1_ctrl[T1_OSC_BIT] ? pins_sync[PIN_OSC]
                                               : pins_sync[PIN_CKI];
    state_next.pin_prev = ext_level;
    if (state_reg.t1_ctrl[T1_SRC_BIT] && ext_level && !state_reg.pin_prev) begin
      state_next.t1_pre = state_reg.t1_pre + 3'h1;
    end
    t1_ps = state_reg.t1_ctrl[T1_PS_LSB +: 2];
    if (t1_ps == 2'h0) begin
      pre_out = ext_level;
    end else begin
      pre_out = state_reg.t1_pre[t1_ps - 2'h1];
    end
    state_next.pre_prev = pre_out;

    // phase sampler stops while the core sleeps
    if ((state_reg.phase == PHASE_Q2 || state_reg.phase == PHASE_Q4) &&
        !sleep_i) begin
      state_next.sampled = pre_out;
    end
    state_next.sampled_prev = state_reg.sampled;

    // first timer increment source
    if (!state_reg.t1_ctrl[T1_ON_BIT]) begin
      t1_inc = 1'b0;
    end else if (!state_reg.t1_ctrl[T1_SRC_BIT]) begin
      t1_inc = instr_tick;
    end else if (state_reg.t1_ctrl[T1_SYNC_BIT]) begin
      t1_inc = pre_out && !state_reg.pre_prev;
    end else begin
      t1_inc = state_reg.sampled && !state_reg.sampled_prev &&
               !sleep_i;
    end
    if (t1_inc) begin
      state_next.t1_count = state_reg.t1_count + 16'h0001;
      if (&state_reg.t1_count) begin
        flag_set[FLAG_T1_BIT] = 1'b1;
      end
    end

    // second timer prescaler
    case (state_reg.t2_ctrl[T2_PS_LSB +: 2])
      2'b00: begin
        t2_limit = T2_DIV_00;
      end
      2'b01: begin
        t2_limit = T2_DIV_01;
      end
      default: begin
        t2_limit = T2_DIV_1X;
      end
    endcase
    if (state_reg.t2_ctrl[T2_RUN_BIT] && instr_tick) begin
      if (state_reg.t2_pre >= t2_limit) begin
        state_next.t2_pre = 4'h0;
        t2_tick = 1'b1;
      end else begin
        state_next.t2_pre = state_reg.t2_pre + 4'h1;
      end
    end

    // period match, postscaler and match flag
    if (t2_tick) begin
      if (state_reg.t2_count == state_reg.t2_period) begin
        state_next.t2_count = 8'h00;
        if (state_reg.t2_post == state_reg.t2_ctrl[T2_POST_LSB +: 4]) begin
          state_next.t2_post = 4'h0;
          flag_set[FLAG_T2_BIT] = 1'b1;
        end else begin
          state_next.t2_post = state_reg.t2_post + 4'h1;
        end
      end else begin
        state_next.t2_count = state_reg.t2_count + 8'h01;
      end
    end

    // read data mux
    case (bus_req_i.addr)
      ADDR_INTCTL: begin
        rd_mux = {state_reg.intctl, 6'h00};
      end
      ADDR_FLAGS: begin
        rd_mux = {6'h00, state_reg.flags};
      end
      ADDR_T1_LO: begin
        rd_mux = state_reg.t1_count[7:0];
      end
      ADDR_T1_HI: begin
        rd_mux = state_reg.t1_count[15:8];
      end
      ADDR_T1_CTRL: begin
        rd_mux = {2'h0, state_reg.t1_ctrl};
      end
      ADDR_T2_COUNT: begin
        rd_mux = state_reg.t2_count;
      end
      ADDR_T2_CTRL: begin
        rd_mux = {1'b0, state_reg.t2_ctrl};
      end
      ADDR_ENABLES: begin
        rd_mux = {6'h00, state_reg.enables};
      end
      ADDR_T2_PERIOD: begin
        rd_mux = state_reg.t2_period;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
    state_next.rdata = bus_req_i.re ? rd_mux : 8'h00;

    // reading the flag register clears it
    if (bus_req_i.re && bus_req_i.addr == ADDR_FLAGS) begin
      state_next.flags = 2'b00;
    end

    // register writes override counting in the same cycle
    if (bus_req_i.we) begin
      case (bus_req_i.addr)
        ADDR_INTCTL: begin
          state_next.intctl = bus_req_i.wdata[INTCTL_LSB +: 2];
        end
        ADDR_FLAGS: begin
          state_next.flags = bus_req_i.wdata[1:0];
        end
        ADDR_T1_LO: begin
          state_next.t1_count[7:0] = bus_req_i.wdata;
          state_next.t1_pre = 3'h0;
        end
        ADDR_T1_HI: begin
          state_next.t1_count[15:8] = bus_req_i.wdata;
          state_next.t1_pre = 3'h0;
        end
        ADDR_T1_CTRL: begin
          state_next.t1_ctrl = bus_req_i.wdata[5:0];
          state_next.t1_pre = 3'h0;
        end
        ADDR_T2_COUNT: begin
          state_next.t2_count = bus_req_i.wdata;
          state_next.t2_pre = 4'h0;
          state_next.t2_post = 4'h0;
        end
        ADDR_T2_CTRL: begin
          state_next.t2_ctrl = bus_req_i.wdata[6:0];
          state_next.t2_pre = 4'h0;
          state_next.t2_post = 4'h0;
        end
        ADDR_ENABLES: begin
          state_next.enables = bus_req_i.wdata[1:0];
        end
        ADDR_T2_PERIOD: begin
          state_next.t2_period = bus_req_i.wdata;
        end
        default: begin
          state_next.t2_period = state_next.t2_period;
        end
      endcase
    end

    // a new event wins over a clear in the same cycle
    state_next.flags = state_next.flags | flag_set;

    state_next.irq = state_next.intctl[INTCTL_GIE_BIT] &&
                     state_next.intctl[INTCTL_PEIE_BIT] &&
                     |(state_next.flags & state_next.enables);
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdata_o = state_reg.rdata;
  assign irq_o = state_reg.irq;

  default clocking dtf_cb @(posedge core_clk_i);
  endclocking
  default disable iff (srst_i);

  timer_mode_a: assert property (
    (state_reg.t1_ctrl[T1_ON_BIT] && !state_reg.t1_ctrl[T1_SRC_BIT] &&
     state_reg.phase == PHASE_Q4 && !bus_req_i.we)
    |=> state_reg.t1_count == $past(state_reg.t1_count) + 16'h0001)
    else $error("timer mode missed an instruction cycle increment");

  sync_ignored_a: assert property (
    (!state_reg.t1_ctrl[T1_SRC_BIT] && state_reg.phase != PHASE_Q4 &&
     !bus_req_i.we)
    |=> $stable(state_reg.t1_count))
    else $error("timer mode count moved off the instruction edge");

  sleep_hold_a: assert property (
    (state_reg.t1_ctrl[T1_SRC_BIT] && !state_reg.t1_ctrl[T1_SYNC_BIT] &&
     sleep_i && !bus_req_i.we)
    |=> $stable(state_reg.t1_count))
    else $error("synced counter advanced during sleep");

  sample_phase_a: assert property (
    $changed(state_reg.sampled)
    |-> ($past(state_reg.phase) == PHASE_Q2 ||
         $past(state_reg.phase) == PHASE_Q4))
    else $error("prescaler output sampled outside second or fourth phase");

  sync_delay_a: assert property (
    (t1_inc && state_reg.t1_ctrl[T1_SRC_BIT] &&
     !state_reg.t1_ctrl[T1_SYNC_BIT])
    |-> $rose(state_reg.sampled) &&
        ($past(state_reg.phase) == PHASE_Q2 ||
         $past(state_reg.phase) == PHASE_Q4))
    else $error("synced increment without a sampled edge");

  t2_reset_a: assert property (
    disable iff (1'b0) srst_i |=> state_reg.t2_count == 8'h00)
    else $error("second timer count not cleared by reset");

  t2_off_a: assert property (
    (!state_reg.t2_ctrl[T2_RUN_BIT] && !bus_req_i.we)
    |=> $stable(state_reg.t2_count))
    else $error("second timer counted while switched off");

  ovf_flag_a: assert property (
    (t1_inc && state_reg.t1_count == 16'hFFFF && !bus_req_i.we)
    |=> state_reg.flags[FLAG_T1_BIT] && state_reg.t1_count == 16'h0000)
    else $error("overflow did not set the first timer flag");

  match_wrap_a: assert property (
    (t2_tick && state_reg.t2_count == state_reg.t2_period && !bus_req_i.we)
    |=> state_reg.t2_count == 8'h00)
    else $error("second timer did not wrap at the period");

  div1_tick_a: assert property (
    (state_reg.t2_ctrl[T2_RUN_BIT] && state_reg.phase == PHASE_Q4 &&
     state_reg.t2_ctrl[T2_PS_LSB +: 2] == 2'b00)
    |-> t2_tick)
    else $error("divide by one missed an instruction cycle");

  div16_tick_a: assert property (
    (t2_tick && state_reg.t2_ctrl[T2_PS_LSB + 1])
    |-> state_reg.t2_pre == T2_DIV_1X)
    else $error("divide by sixteen ticked early");

  post_flag_a: assert property (
    (t2_tick && state_reg.t2_count == state_reg.t2_period &&
     state_reg.t2_post == state_reg.t2_ctrl[T2_POST_LSB +: 4])
    |=> state_reg.flags[FLAG_T2_BIT])
    else $error("postscaler completed without a match flag");

  post_step_a: assert property (
    (t2_tick && state_reg.t2_count == state_reg.t2_period &&
     state_reg.t2_post != state_reg.t2_ctrl[T2_POST_LSB +: 4] &&
     !bus_req_i.we)
    |=> state_reg.t2_post == $past(state_reg.t2_post) + 4'h1)
    else $error("postscaler did not advance on a period match");

  flag_sticky_a: assert property (
    (state_reg.flags[FLAG_T1_BIT] && !(bus_req_i.addr == ADDR_FLAGS &&
     (bus_req_i.re || bus_req_i.we)))
    |=> state_reg.flags[FLAG_T1_BIT])
    else $error("overflow flag dropped without software");

  ctrl_write_a: assert property (
    (bus_req_i.we && (bus_req_i.addr == ADDR_T2_CTRL ||
                      bus_req_i.addr == ADDR_T2_COUNT))
    |=> state_reg.t2_pre == 4'h0 && state_reg.t2_post == 4'h0)
    else $error("second timer write left a scaler running");

  sleep_prescale_a: assert property (
    (state_reg.t1_ctrl[T1_SRC_BIT] && !state_reg.t1_ctrl[T1_OSC_BIT] &&
     sleep_i && pins_sync[PIN_CKI] && !state_reg.pin_prev &&
     !bus_req_i.we)
    |=> state_reg.t1_pre == $past(state_reg.t1_pre) + 3'h1)
    else $error("prescaler stopped while the core sleeps");

endmodule // dtf_timers

`default_nettype wire

// ---- verification/dtf_ext_src.sv ----
`timescale 1ns/10ps
`default_nettype none

module dtf_ext_src (
  // clock
  input wire logic core_clk_i,
  // external clock pins
  output logic osc_in_o,
  output logic clk_pin_o
);
  initial begin
    osc_in_o = 1'b0;
    clk_pin_o = 1'b0;
  end

  // high three, low three core cycles; stands low between bursts
  task automatic pulse(input int n, input bit on_osc);
    repeat (n) begin
      @(posedge core_clk_i);
      if (on_osc) osc_in_o <= 1'b1;
      else clk_pin_o <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      osc_in_o <= 1'b0;
      clk_pin_o <= 1'b0;
      repeat (2) @(posedge core_clk_i);
    end
    // let the synchroniser and counter settle
    repeat (8) @(posedge core_clk_i);
  endtask
endmodule // dtf_ext_src

`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import dtf_pkg::*;
  logic core_clk;
  logic srst;
  dtf_bus_req_type bus_req;
  logic [7:0] rdata;
  logic osc_in;
  logic clk_pin;
  logic sleep;
  logic irq;
  logic [7:0] rd_val;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  dtf_timers uut (.core_clk_i(core_clk), .srst_i(srst), .bus_req_i(bus_req),
    .rdata_o(rdata), .osc_in_i(osc_in), .clk_pin_i(clk_pin),
    .sleep_i(sleep), .irq_o(irq));
  dtf_ext_src src (.core_clk_i(core_clk), .osc_in_o(osc_in),
    .clk_pin_o(clk_pin));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic conclude;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge core_clk);
    bus_req.we <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    bus_req <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge core_clk);
    bus_req.re <= 1'b0;
    #1 rd_val = rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    rd(a);
    check(rd_val, exp);
  endtask

  task automatic irqc(input logic exp);
    repeat (2) @(posedge core_clk);
    #1 check({7'h00, irq}, {7'h00, exp});
  endtask

  task automatic t_reset;
    rdc(ADDR_INTCTL, 8'h00);
    rdc(ADDR_FLAGS, 8'h00);
    rdc(ADDR_T2_COUNT, 8'h00);
    rdc(ADDR_T2_CTRL, 8'h00);
    rdc(ADDR_ENABLES, 8'h00);
    rdc(ADDR_T2_PERIOD, 8'hFF);
    rdc(ADDR_T1_LO, 8'h00);
    // unmapped place ignores writes and reads zero
    wr(8'h13, 8'hFF);
    rdc(8'h13, 8'h00);
    wr(ADDR_T2_PERIOD, 8'h5A);
    rdc(ADDR_T2_PERIOD, 8'h5A);
    wr(ADDR_T2_CTRL, 8'hFF);
    rdc(ADDR_T2_CTRL, 8'h7F);
    wr(ADDR_T2_CTRL, 8'h00);
  endtask

  // forty core cycles of running hold exactly ten instruction ticks
  task automatic t_first_timer_count(input logic [7:0] ctl);
    wr(ADDR_T1_LO, 8'h00);
    wr(ADDR_T1_HI, 8'h00);
    wr(ADDR_T1_CTRL, ctl);
    repeat (38) @(posedge core_clk);
    wr(ADDR_T1_CTRL, 8'h00);
    rdc(ADDR_T1_LO, 8'h0A);
  endtask

  task automatic t_cnt(input logic [7:0] ctl, input int n, input bit on_osc,
                       input logic [7:0] exp);
    wr(ADDR_T1_LO, 8'h00);
    wr(ADDR_T1_HI, 8'h00);
    wr(ADDR_T1_CTRL, ctl);
    src.pulse(n, on_osc);
    rdc(ADDR_T1_LO, exp);
  endtask

  task automatic t_ovf;
    wr(ADDR_T1_HI, 8'hFF);
    wr(ADDR_T1_LO, 8'hFE);
    wr(ADDR_T1_CTRL, 8'h07);
    src.pulse(2, 1'b0);
    rdc(ADDR_T1_HI, 8'h00);
    irqc(1'b0);
    wr(ADDR_ENABLES, 8'h01);
    irqc(1'b0);
    wr(ADDR_INTCTL, 8'hC0);
    irqc(1'b1);
    wr(ADDR_ENABLES, 8'h00);
    irqc(1'b0);
    wr(ADDR_ENABLES, 8'h01);
    rdc(ADDR_FLAGS, 8'h01);
    irqc(1'b0);
    rdc(ADDR_FLAGS, 8'h00);
  endtask

  task automatic t2_arm(input logic [7:0] per, input logic [7:0] ctl);
    wr(ADDR_T2_CTRL, 8'h00);
    wr(ADDR_T2_COUNT, 8'h00);
    wr(ADDR_T2_PERIOD, per);
    rd(ADDR_FLAGS);
    wr(ADDR_T2_CTRL, ctl);
  endtask

  // period zero: one match flag per prescaled tick
  task automatic t_t2_pre;
    int r;
    for (int ps = 0; ps < 4; ps++) begin
      r = (ps == 0) ? 1 : (ps == 1) ? 4 : 16;
      t2_arm(8'h00, {5'b00001, ps[1:0]});
      if (r > 1) begin
        repeat (4 * r - 8) @(posedge core_clk);
        rdc(ADDR_FLAGS, 8'h00);
      end
      repeat (8) @(posedge core_clk);
      rdc(ADDR_FLAGS, 8'h02);
    end
  endtask

  // period two at 1:2 postscale: flag on the sixth tick only
  task automatic t_t2_post;
    t2_arm(8'h02, 8'h0C);
    repeat (18) @(posedge core_clk);
    rdc(ADDR_FLAGS, 8'h00);
    repeat (8) @(posedge core_clk);
    rdc(ADDR_FLAGS, 8'h02);
    t2_arm(8'h00, 8'h00);
    repeat (20) @(posedge core_clk);
    rdc(ADDR_FLAGS, 8'h00);
    rdc(ADDR_T2_COUNT, 8'h00);
  endtask

  initial begin
    srst = 1'b1;
    bus_req = '0;
    sleep = 1'b0;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    t_first_timer_count(8'h01);
    t_first_timer_count(8'h05);
    t_cnt(8'h07, 5, 1'b0, 8'h05);
    t_cnt(8'h0F, 5, 1'b1, 8'h05);
    t_cnt(8'h0F, 5, 1'b0, 8'h00);
    t_cnt(8'h27, 8, 1'b0, 8'h02);
    t_cnt(8'h17, 6, 1'b0, 8'h03);
    t_cnt(8'h37, 8, 1'b0, 8'h01);
    t_cnt(8'h13, 6, 1'b0, 8'h03);
    t_cnt(8'h03, 4, 1'b0, 8'h04);
    @(posedge core_clk);
    sleep <= 1'b1;
    t_cnt(8'h03, 4, 1'b0, 8'h00);
    @(posedge core_clk);
    sleep <= 1'b0;
    t_ovf();
    t_t2_pre();
    t_t2_post();
    @(posedge core_clk);
    srst <= 1'b1;
    @(posedge core_clk);
    srst <= 1'b0;
    t_reset();
    conclude();
  end
endmodule // testbench

`default_nettype wire
